// ### logic/cable_eq_driver_register_page.sv
// Register page for the cable equalizer and output drivers
// Notes on behaviour
// RL1: Lock pin shows coarse adaptation done when select is 0, carrier when 1.
// RL2: Override set: primary power save follows the two-bit select field.
// RL3: Override clear: power save whenever no signal on primary input.
// RL4: Select 00 save on absence, 01 never, 11 forced; 10 reserved.
// RL5: The unused input is always powered down whatever the settings.
// RL6: Soft-reset bit restores page defaults and clears itself; software reinitializes.
// RL7: Adaptation-done flag reads 1 once adaptation finished, else 0.
// RL8: Carrier bit reads 1 while signal present on primary input.
// RL9: Rate field reads 001, 010 or 100 for the three bands.
// RL10: Power-save status bit reads 1 while power save is active.
// RL11: Second-output mute bit reads 1 while that driver is muted.
// RL12: First-output mute bit reads 1 while that driver is muted.
// RL13: A muted driver holds its output at common mode.
// RL14: Six-bit mute threshold, default all ones, sets the muting level.
// RL15: Reserved fields keep written values and change no behaviour.
`timescale 1ns/10ps
`default_nettype none
`include "eq_page_defs.svh"
module cable_eq_driver_register_page (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic coarse_adapt_done,
  input wire logic adaptation_done,
  input wire logic primary_signal_present,
  input wire logic [2:0] rate_detect,
  input wire logic [5:0] cable_loss_level,
  input wire logic input_select,
  output logic lock_n,
  output logic carrier_present_n,
  output logic primary_power_down,
  output logic secondary_power_down,
  output logic first_output_muted,
  output logic second_output_muted
);
  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic lock_sel;
  logic ps_ovr;
  logic [1:0] ps_mode;
  logic [2:0] ctrl_rsvd;
  logic [5:0] mute_threshold;
  logic [1:0] mute_rsvd;
  logic next_lock_sel;
  logic next_ps_ovr;
  logic [1:0] next_ps_mode;
  logic [2:0] next_ctrl_rsvd;
  logic [5:0] next_mute_threshold;
  logic [1:0] next_mute_rsvd;
  logic soft_reset;
  logic page_clear;
  logic wr_ctrl;
  logic wr_mute;
  logic wr_spare;
  logic [7:0] rst_ctrl;
  logic [7:0] rst_mute;

  assign rst_ctrl = `RST_CTRL;
  assign rst_mute = `RST_MUTE;
  assign wr_ctrl = reg_wr && reg_addr == `OFF_CTRL;
  assign wr_mute = reg_wr && reg_addr == `OFF_MUTE;
  assign wr_spare = reg_wr && reg_addr >= `OFF_SPARE_LO &&
                    reg_addr <= `OFF_SPARE_HI;
  // The reset bit is never stored, so it always reads back 0
  assign soft_reset = wr_ctrl && reg_wdata[`BIT_SOFT_RST]; // [RL6]
  assign page_clear = reset || soft_reset;

  always_comb begin
    next_lock_sel = lock_sel;
    next_ps_ovr = ps_ovr;
    next_ps_mode = ps_mode;
    next_ctrl_rsvd = ctrl_rsvd;
    next_mute_threshold = mute_threshold;
    next_mute_rsvd = mute_rsvd;
    if (page_clear) begin
      next_lock_sel = rst_ctrl[`BIT_LOCK_SEL]; // [RL6]
      next_ps_ovr = rst_ctrl[`BIT_PS_OVR];
      next_ps_mode = rst_ctrl[`PS_SEL_HI:`PS_SEL_LO];
      next_ctrl_rsvd = {rst_ctrl[`BIT_CTRL_RSVD6], rst_ctrl[1:0]};
      next_mute_threshold = rst_mute[`MUTE_HI:0]; // [RL14]
      next_mute_rsvd = rst_mute[7:6];
    end else begin
      if (wr_ctrl) begin
        next_lock_sel = reg_wdata[`BIT_LOCK_SEL];
        next_ps_ovr = reg_wdata[`BIT_PS_OVR];
        next_ps_mode = reg_wdata[`PS_SEL_HI:`PS_SEL_LO];
        next_ctrl_rsvd = {reg_wdata[`BIT_CTRL_RSVD6],
                          reg_wdata[1:0]}; // [RL15]
      end
      if (wr_mute) begin
        next_mute_threshold = reg_wdata[`MUTE_HI:0]; // [RL14]
        next_mute_rsvd = reg_wdata[7:6]; // [RL15]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    lock_sel <= next_lock_sel;
    ps_ovr <= next_ps_ovr;
    ps_mode <= next_ps_mode;
    ctrl_rsvd <= next_ctrl_rsvd;
    mute_threshold <= next_mute_threshold;
    mute_rsvd <= next_mute_rsvd;
  end

  // ****************************************************************
  // Power save and spare storage
  // ****************************************************************
  logic [7:0] spare_rd_data;
  logic primary_unused;

  assign primary_unused = input_select;

  power_save_ctrl u_power_save (
    .sys_clk(sys_clk),
    .reset(reset),
    .override(ps_ovr),
    .mode(ps_mode),
    .signal_present(primary_signal_present),
    .primary_unused(primary_unused),
    .powersave(primary_power_down)
  );

  spare_reg_mem #(
    .DEPTH(5),
    .WIDTH(8)
  ) u_spare (
    .sys_clk(sys_clk),
    .clear(page_clear),
    .wr_en(wr_spare),
    .wr_index(3'(reg_addr - `OFF_SPARE_LO)),
    .wr_data(reg_wdata),
    .rd_index(3'(reg_addr - `OFF_SPARE_LO)),
    .rd_data(spare_rd_data)
  );

  // ****************************************************************
  // Pins and observed status
  // ****************************************************************
  logic adapt_seen;
  logic carrier_seen;
  logic [2:0] rate_seen;
  logic next_lock_n;
  logic next_secondary_down;
  logic next_mute0;
  logic next_mute1;
  logic next_carrier_n;
  logic mute_level;

  // Loss above the threshold mutes; the all-ones default never trips
  assign mute_level = cable_loss_level > mute_threshold; // [RL14]

  always_comb begin
    if (lock_sel) begin
      next_lock_n = !primary_signal_present; // [RL1]
    end else begin
      next_lock_n = !coarse_adapt_done; // [RL1]
    end
    next_secondary_down = !input_select; // [RL5]
    next_carrier_n = !primary_signal_present;
    // A muted driver parks at common mode instead of toggling
    next_mute0 = mute_level || primary_power_down; // [RL13]
    next_mute1 = mute_level || primary_power_down; // [RL13]
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lock_n <= 1'b1;
      carrier_present_n <= 1'b1;
      secondary_power_down <= 1'b1;
      first_output_muted <= 1'b1;
      second_output_muted <= 1'b1;
      adapt_seen <= 1'b0;
      carrier_seen <= 1'b0;
      rate_seen <= 3'h0;
    end else begin
      lock_n <= next_lock_n;
      carrier_present_n <= next_carrier_n;
      secondary_power_down <= next_secondary_down;
      first_output_muted <= next_mute0;
      second_output_muted <= next_mute1;
      adapt_seen <= adaptation_done; // [RL7]
      carrier_seen <= primary_signal_present; // [RL8]
      rate_seen <= rate_detect; // [RL9]
    end
  end

  // ****************************************************************
  // Read path, two cycles from request to data
  // ****************************************************************
  logic [7:0] local_rdata;
  logic [7:0] next_local_rdata;
  logic [7:0] next_reg_rdata;
  logic rd_stage;
  logic spare_stage;
  logic next_spare_stage;
  logic [7:0] rst_eq;

  assign rst_eq = `RST_EQ_STAT;

  always_comb begin
    next_local_rdata = 8'h00;
    unique case (reg_addr)
      `OFF_CTRL: begin
        next_local_rdata = {lock_sel, ctrl_rsvd[2], ps_ovr, ps_mode,
                            1'b0, ctrl_rsvd[1:0]};
      end
      `OFF_EQ_STAT: begin
        next_local_rdata = {rst_eq[7:1], adapt_seen}; // [RL7]
      end
      `OFF_RATE_STAT: begin
        next_local_rdata = {1'b0, carrier_seen, rate_seen, // [RL8] [RL9]
                            primary_power_down, // [RL10]
                            second_output_muted, // [RL11]
                            first_output_muted}; // [RL12]
      end
      `OFF_MUTE: begin
        next_local_rdata = {mute_rsvd, mute_threshold};
      end
      default: begin
        next_local_rdata = 8'h00;
      end
    endcase
    next_spare_stage = reg_addr >= `OFF_SPARE_LO &&
                       reg_addr <= `OFF_SPARE_HI;
    next_reg_rdata = spare_stage ? spare_rd_data : local_rdata;
    if (!rd_stage) begin
      next_reg_rdata = reg_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      local_rdata <= 8'h00;
      rd_stage <= 1'b0;
      spare_stage <= 1'b0;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      local_rdata <= next_local_rdata;
      rd_stage <= reg_rd;
      spare_stage <= next_spare_stage;
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= rd_stage;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  lock_source_a: assert property (@(posedge sys_clk) // [RL1]
    disable iff (reset)
    1'b1 |=> lock_n == !($past(lock_sel) ? $past(primary_signal_present)
                                         : $past(coarse_adapt_done)))
    else $error("lock pin shows wrong source");
  soft_reset_a: assert property (@(posedge sys_clk) // [RL6]
    disable iff (reset)
    soft_reset |=> !ps_ovr && ps_mode == 2'h1 && !lock_sel &&
                   ctrl_rsvd == 3'h0 && mute_threshold == 6'h3f &&
                   mute_rsvd == 2'h0)
    else $error("soft reset did not restore defaults");
  ctrl_write_a: assert property (@(posedge sys_clk) // [RL2] [RL15]
    disable iff (reset)
    wr_ctrl && !reg_wdata[`BIT_SOFT_RST] |=>
      {lock_sel, ctrl_rsvd[2], ps_ovr, ps_mode, ctrl_rsvd[1:0]} ==
      $past({reg_wdata[7:3], reg_wdata[1:0]}))
    else $error("control write not stored");
  read_latency_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_rd |-> ##2 reg_rvalid)
    else $error("read answer not two cycles later");
  no_stray_answer_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    !reg_rd |-> ##2 !reg_rvalid)
    else $error("read answer without request");
  rdata_hold_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    !reg_rvalid |-> $stable(reg_rdata))
    else $error("read data changed without answer");
  mute_cause_a: assert property (@(posedge sys_clk) // [RL13]
    disable iff (reset)
    primary_power_down |=> first_output_muted && second_output_muted)
    else $error("outputs not muted in power save");
  mute_level_a: assert property (@(posedge sys_clk) // [RL14]
    disable iff (reset)
    cable_loss_level > mute_threshold |=>
      first_output_muted && second_output_muted)
    else $error("outputs not muted above threshold");
  drivers_active_a: assert property (@(posedge sys_clk) // [RL13]
    disable iff (reset)
    !primary_power_down && cable_loss_level <= mute_threshold |=>
      !first_output_muted && !second_output_muted)
    else $error("outputs muted without cause");
  secondary_down_a: assert property (@(posedge sys_clk) // [RL5]
    disable iff (reset)
    1'b1 |=> secondary_power_down == !$past(input_select))
    else $error("unused secondary input not powered down");
  psave_status_a: assert property (@(posedge sys_clk) // [RL10]
    disable iff (reset)
    reg_rd && reg_addr == 4'h2 |->
      ##2 reg_rdata[2] == $past(primary_power_down, 2))
    else $error("power save status not reported");
  unmapped_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_rd && reg_addr > 4'h8 |-> ##2 reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ### logic/eq_page_defs.svh
// Offsets, field positions, reset values and timing of the equalizer page
`ifndef EQ_PAGE_DEFS_SVH
`define EQ_PAGE_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFF_CTRL 4'h0
`define OFF_EQ_STAT 4'h1
`define OFF_RATE_STAT 4'h2
`define OFF_MUTE 4'h3
`define OFF_SPARE_LO 4'h4
`define OFF_SPARE_HI 4'h8

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_LOCK_SEL 7
`define BIT_CTRL_RSVD6 6
`define BIT_PS_OVR 5
`define PS_SEL_HI 4
`define PS_SEL_LO 3
`define BIT_SOFT_RST 2
`define BIT_ADAPT 0
`define BIT_CARRIER 6
`define RATE_HI 5
`define RATE_LO 3
`define BIT_PS_STAT 2
`define BIT_MUTE1 1
`define BIT_MUTE0 0
`define MUTE_HI 5

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define RST_CTRL 8'h08
`define RST_EQ_STAT 8'h80
`define RST_RATE_STAT 8'h07
`define RST_MUTE 8'h3f
`define RST_SPARE4 8'h00
`define RST_SPARE5 8'h00
`define RST_SPARE6 8'ha0
`define RST_SPARE7 8'h24
`define RST_SPARE8 8'h27
`define RATE_LOW_BAND 3'h1
`define RATE_MID_BAND 3'h2
`define RATE_HIGH_BAND 3'h4
`define READ_LATENCY 2

`endif

// ### logic/eq_page_pkg.sv
// Types used by the power-save module of the equalizer page
`default_nettype none
package eq_page_pkg;
  typedef enum logic [1:0] {
    PS_ON = 2'h0,
    PS_SAVE = 2'h1,
    PS_UNUSED = 2'h3
  } ps_state_type;

  typedef enum logic [1:0] {
    MODE_ON_ABSENCE = 2'h0,
    MODE_NEVER = 2'h1,
    MODE_RESERVED = 2'h2,
    MODE_FORCE = 2'h3
  } ps_mode_type;
endpackage
`default_nettype wire

// ### logic/spare_reg_mem.sv
// Storage for the spare registers of the page, registered read data
`timescale 1ns/10ps
`default_nettype none
`include "eq_page_defs.svh"
module spare_reg_mem #(
  parameter int DEPTH = 5,
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [2:0] wr_index,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [2:0] rd_index,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [WIDTH-1:0] next_rd_data;

  function automatic logic [WIDTH-1:0] default_of(input int idx);
    case (idx)
      0: default_of = WIDTH'(`RST_SPARE4);
      1: default_of = WIDTH'(`RST_SPARE5);
      2: default_of = WIDTH'(`RST_SPARE6);
      3: default_of = WIDTH'(`RST_SPARE7);
      default: default_of = WIDTH'(`RST_SPARE8);
    endcase
  endfunction

  // ****************************************************************
  // Entries
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_comb begin
        if (clear) begin
          next_mem[i] = default_of(i); // [RL6]
        end else if (wr_en && wr_index == 3'(i)) begin
          next_mem[i] = wr_data; // [RL15]
        end else begin
          next_mem[i] = mem[i];
        end
      end

      always_ff @(posedge sys_clk) begin
        mem[i] <= next_mem[i];
      end
    end
  endgenerate

  always_comb begin
    if (int'(rd_index) < DEPTH) begin
      next_rd_data = mem[rd_index];
    end else begin
      next_rd_data = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data <= next_rd_data;
  end
endmodule
`default_nettype wire

// ### logic/power_save_ctrl.sv
// Power-save state machine for the primary cable input
`timescale 1ns/10ps
`default_nettype none
module power_save_ctrl (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic override,
  input wire logic [1:0] mode,
  input wire logic signal_present,
  input wire logic primary_unused,
  output logic powersave
);
  eq_page_pkg::ps_state_type state;
  eq_page_pkg::ps_state_type next_state;
  logic want_save;
  logic next_powersave;

  always_comb begin
    want_save = !signal_present; // [RL3]
    if (override) begin
      // Reserved code behaves like power save on absence
      unique case (eq_page_pkg::ps_mode_type'(mode))
        eq_page_pkg::MODE_ON_ABSENCE: want_save = !signal_present; // [RL4]
        eq_page_pkg::MODE_NEVER: want_save = 1'b0; // [RL4]
        eq_page_pkg::MODE_RESERVED: want_save = !signal_present;
        eq_page_pkg::MODE_FORCE: want_save = 1'b1; // [RL2] [RL4]
      endcase
    end
    if (primary_unused) begin
      next_state = eq_page_pkg::PS_UNUSED; // [RL5]
    end else if (want_save) begin
      next_state = eq_page_pkg::PS_SAVE;
    end else begin
      next_state = eq_page_pkg::PS_ON;
    end
    next_powersave = (next_state != eq_page_pkg::PS_ON);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= eq_page_pkg::PS_SAVE;
      powersave <= 1'b1;
    end else begin
      state <= next_state;
      powersave <= next_powersave;
    end
  end

  psave_force_a: assert property (@(posedge sys_clk) // [RL4]
    disable iff (reset)
    override && mode == 2'h3 |=> powersave)
    else $error("forced power save not entered");
  psave_never_a: assert property (@(posedge sys_clk) // [RL4]
    disable iff (reset)
    override && mode == 2'h1 && !primary_unused |=> !powersave)
    else $error("power save entered while disabled");
  psave_absent_a: assert property (@(posedge sys_clk) // [RL4]
    disable iff (reset)
    override && !mode[0] && !primary_unused |=>
      powersave == !$past(signal_present))
    else $error("power save on absence wrong");
  psave_auto_a: assert property (@(posedge sys_clk) // [RL3]
    disable iff (reset)
    !override && !primary_unused |=> powersave == !$past(signal_present))
    else $error("automatic power save wrong");
  unused_down_a: assert property (@(posedge sys_clk) // [RL5]
    disable iff (reset)
    primary_unused ##1 primary_unused |->
      powersave && state == eq_page_pkg::PS_UNUSED)
    else $error("unused input not powered down");
endmodule
`default_nettype wire

// ### tb/tb_cable_eq_driver_register_page.sv
// Self-checking bench for the equalizer and driver register page
`timescale 1ns/10ps
`default_nettype none
module tb_cable_eq_driver_register_page;
  // ****************************************************************
  // Clock, reset and stimulus signals
  // ****************************************************************
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic coarse_adapt_done = 1'b0;
  logic adaptation_done = 1'b0;
  logic primary_signal_present = 1'b1;
  logic [2:0] rate_detect = 3'h1;
  logic [5:0] cable_loss_level = 6'h00;
  logic input_select = 1'b0;
  logic lock_n;
  logic carrier_present_n;
  logic primary_power_down;
  logic secondary_power_down;
  logic first_output_muted;
  logic second_output_muted;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] d;

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  cable_eq_driver_register_page i_dut (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .coarse_adapt_done(coarse_adapt_done),
    .adaptation_done(adaptation_done),
    .primary_signal_present(primary_signal_present),
    .rate_detect(rate_detect), .cable_loss_level(cable_loss_level),
    .input_select(input_select), .lock_n(lock_n),
    .carrier_present_n(carrier_present_n),
    .primary_power_down(primary_power_down),
    .secondary_power_down(secondary_power_down),
    .first_output_muted(first_output_muted),
    .second_output_muted(second_output_muted)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      $display("CHECK FAILED at %0t: run took too long", $time);
      finish_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Answer is awaited under a bound; a missing answer counts as mismatch
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    bit got;
    got = 1'b0;
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    for (int k = 0; k < 4 && !got; k++) begin
      @(posedge sys_clk);
      if (reg_rvalid === 1'b1) begin
        got = 1'b1;
        d = reg_rdata;
      end
    end
    if (!got) begin
      d = 8'hxx;
    end
    check(d, e);
  endtask

  task automatic outs(input logic ppd, input logic mute);
    wait_cyc(3);
    check(8'(primary_power_down), 8'(ppd));
    check(8'(first_output_muted), 8'(mute));
    check(8'(second_output_muted), 8'(mute));
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_defaults();
    rdc(4'h0, 8'h08);
    rdc(4'h1, 8'h80);
    rdc(4'h3, 8'h3f);
    rdc(4'h4, 8'h00);
    rdc(4'h5, 8'h00);
    rdc(4'h6, 8'ha0);
    rdc(4'h7, 8'h24);
    rdc(4'h8, 8'h27);
    rdc(4'h9, 8'h00);
    rdc(4'hf, 8'h00);
  endtask

  task automatic t_status();
    logic [2:0] codes [3] = '{3'h1, 3'h2, 3'h4};
    adaptation_done <= 1'b1;
    wr(4'h1, 8'h00);
    rdc(4'h1, 8'h81);
    foreach (codes[i]) begin
      rate_detect <= codes[i];
      wr(4'h2, 8'hff);
      rdc(4'h2, {2'b01, codes[i], 3'b000});
    end
    primary_signal_present <= 1'b0;
    outs(1'b1, 1'b1);
    check(8'(carrier_present_n), 8'h01);
    rdc(4'h2, 8'h27);
    primary_signal_present <= 1'b1;
    outs(1'b0, 1'b0);
    check(8'(carrier_present_n), 8'h00);
  endtask

  task automatic t_lock();
    wr(4'h0, 8'h08);
    wait_cyc(3);
    check(8'(lock_n), 8'h01);
    coarse_adapt_done <= 1'b1;
    wait_cyc(3);
    check(8'(lock_n), 8'h00);
    wr(4'h0, 8'h88);
    primary_signal_present <= 1'b0;
    wait_cyc(3);
    check(8'(lock_n), 8'h01);
    coarse_adapt_done <= 1'b0;
    primary_signal_present <= 1'b1;
    wait_cyc(3);
    check(8'(lock_n), 8'h00);
  endtask

  task automatic t_ps();
    logic exp;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        primary_signal_present <= s[0];
        wr(4'h0, 8'h20 | 8'(m << 3));
        exp = (m == 1) ? 1'b0 : (m == 3) ? 1'b1 : !s[0];
        outs(exp, exp);
        rdc(4'h2, {1'b0, s[0], 3'h4, exp, exp, exp});
      end
    end
    wr(4'h0, 8'h28);
    input_select <= 1'b1;
    outs(1'b1, 1'b1);
    check(8'(secondary_power_down), 8'h00);
    input_select <= 1'b0;
    outs(1'b0, 1'b0);
    check(8'(secondary_power_down), 8'h01);
  endtask

  task automatic t_mute();
    wr(4'h0, 8'h08);
    wr(4'h3, 8'hd0);
    cable_loss_level <= 6'h10;
    outs(1'b0, 1'b0);
    cable_loss_level <= 6'h11;
    outs(1'b0, 1'b1);
    rdc(4'h3, 8'hd0);
    cable_loss_level <= 6'h00;
    wr(4'h0, 8'h4b);
    outs(1'b0, 1'b0);
    rdc(4'h0, 8'h4b);
    wr(4'h5, 8'h5a);
    rdc(4'h5, 8'h5a);
  endtask

  task automatic t_soft();
    wr(4'h3, 8'h01);
    wr(4'h8, 8'h00);
    wr(4'h0, 8'hfc);
    rdc(4'h0, 8'h08);
    rdc(4'h3, 8'h3f);
    rdc(4'h5, 8'h00);
    rdc(4'h8, 8'h27);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    wait_cyc(5);
    check(8'(lock_n), 8'h01);
    check(8'(primary_power_down), 8'h01);
    check({6'h0, second_output_muted, first_output_muted}, 8'h03);
    reset <= 1'b0;
    t_defaults();
    t_status();
    t_lock();
    t_ps();
    t_mute();
    t_soft();
    finish_test();
  end
endmodule
`default_nettype wire
